// ### roc_defines.svh
// Purpose: offsets, field positions, reset values and timing for the relay
//          output controller
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   definitions only
`ifndef ROC_DEFINES_SVH
`define ROC_DEFINES_SVH
// timing
`define ROC_CLK_HZ        25000000
`define ROC_TICK_S        1
`define ROC_DEB_MS        10
`define ROC_MAX_DLY_S     13'h1770
// global registers
`define ROC_A_STATUS      12'h000
`define ROC_A_REMOTE      12'h004
`define ROC_A_PORT_CFG    12'h008
`define ROC_A_CONC_IDX    12'h00C
`define ROC_A_CONC        12'h010
`define ROC_A_DET_W1      12'h014
`define ROC_A_DET_W2      12'h018
`define ROC_A_DET_AL      12'h01C
`define ROC_A_DET_FAIL    12'h020
`define ROC_A_DET_MEAS    12'h024
`define ROC_A_DET_SERV    12'h028
`define ROC_A_MUTE_SRC    12'h02C
// per-output block: base + 0x20 * output index
`define ROC_A_OUT_BASE    12'h100
`define ROC_O_CFG         3'h0
`define ROC_O_ZONE        3'h1
`define ROC_O_DELAY       3'h2
`define ROC_O_DEACT       3'h3
`define ROC_O_CANCEL      3'h4
`define ROC_O_FORCE       3'h5
// output configuration bits
`define ROC_C_W1          0
`define ROC_C_W2          1
`define ROC_C_AL          2
`define ROC_C_FAIL        3
`define ROC_C_MEAS        4
`define ROC_C_SERV        5
`define ROC_C_HOLD        6
`define ROC_C_VALVE       7
`define ROC_C_NEG         8
`define ROC_C_HYST        9
// source vector bits
`define ROC_S_LOCAL       0
`define ROC_S_REMOTE      4
`define ROC_S_BTN_CANCEL  20
`define ROC_S_BTN_EXT     21
`define ROC_S_BTN_BUZZ    22
// reset values
`define ROC_RST_CFG       {10'h108, 10'h020, 10'h010, 10'h004, \
                           10'h041, 10'h004, 10'h002, 10'h001}
`define ROC_RST_ZONE      32'hFFFFFFFF
`define ROC_RST_MUTE      23'h400011
`define ROC_RST_DEACT4    23'h200022
`define ROC_RST_CANCEL3   23'h100044
`define ROC_RST_FORCE     23'h000088
`define ROC_RST_PORT      16'h0111
`define ROC_VALVE_LAST    3'h6
`endif

// ### roc_pkg.sv
// Purpose: state types of the relay output controller
// Assumes: eight outputs, four local inputs, sixteen remote flags
// Notes:   constants live in roc_defines.svh
package roc_pkg;
  typedef struct packed {
    logic [7:0][9:0]  cfg;
    logic [7:0][31:0] zone;
    logic [7:0][12:0] on_dly;
    logic [7:0][12:0] off_dly;
    logic [7:0][22:0] deact_src;
    logic [7:0][22:0] cancel_src;
    logic [7:0][22:0] force_src;
    logic [22:0]      mute_src;
    logic [15:0]      remote;
    logic [15:0]      port_cfg;
    logic [4:0]       conc_idx;
    logic [24:0]      tick_cnt;
    logic             tick;
    logic [7:0][12:0] tmr;
    logic [7:0]       dly_st;
    logic [7:0]       hold;
    logic [7:0]       tdeact;
    logic [7:0]       act;
    logic [7:0][2:0]  vph;
    logic [7:0]       relay;
    logic [22:0]      src;
    logic             buzz_mute;
    logic [31:0]      prdata;
  } roc_state_t;

  typedef struct packed {
    logic [3:0]       s1;
    logic [3:0]       s2;
    logic [3:0]       clean;
    logic [3:0][17:0] cnt;
  } roc_deb_state_t;
endpackage

// ### roc_di_if.sv
// Purpose: carries local binary inputs to and from the debouncer
// Assumes: single pclk domain
// Notes:   raw is sampled, clean is debounced
`timescale 1ns/100ps
interface roc_di_if;
  logic [3:0] raw;
  logic [3:0] clean;
  modport deb  (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ### roc_debounce.sv
// Purpose: synchronise and debounce the four local binary inputs
// Assumes: inputs may bounce for less than the debounce time
// Notes:   a level must stay stable DEB_CYCLES clocks to be accepted
`timescale 1ns/100ps
module roc_debounce #(
  parameter int DEB_CYCLES = 250000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // inputs
  roc_di_if.deb    di
);
  roc_pkg::roc_deb_state_t s_q;
  roc_pkg::roc_deb_state_t s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = di.raw;
    s_d.s2 = s_q.s1;
    for (int i = 0; i < 4; i++) begin
      if (s_q.s2[i] == s_q.clean[i]) begin
        s_d.cnt[i] = 18'h00000;
      end else if (s_q.cnt[i] == 18'(DEB_CYCLES - 1)) begin
        s_d.clean[i] = s_q.s2[i];
        s_d.cnt[i]   = 18'h00000;
      end else begin
        s_d.cnt[i] = s_q.cnt[i] + 18'h00001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign di.clean = s_q.clean;

  property p_deb_stable;
    @(posedge pclk) disable iff (!presetn)
    $changed(s_q.clean[0]) |-> $past(s_q.cnt[0]) == 18'(DEB_CYCLES - 1);
  endproperty
  a_deb_stable: assert property (p_deb_stable)
    else $error("debounced input changed before the stable time");
endmodule

// ### roc_relay_ctrl.sv
// Purpose: relay output controller with apb register file
// Assumes: detector flags are synchronous levels; buttons are levels
// Notes:   overview of the eight outputs follows
// Overview of operation
// - each relay is either activated (coil energised) or deactivated
// - any output fires on any threshold mix over a detector zone
// - output can fire on cumulative failure, including unit failure
// - hysteresis option releases only below the first warning level
// - switch-on delay from one second to one hundred minutes
// - switch-off delay from one second to one hundred minutes
// - hold-on keeps output active until a cancel request after excitation ends
// - active output can be temporarily deactivated by a request
// - valve mode gives three one-second pulses with one-second pauses
// - outputs one to three follow warning one, two and alarm
// - output four latches on warning one, cancel after it clears
// - output five follows alarm and may be muted by button
// - outputs six and seven follow measurement and service modes
// - output eight is active only while nothing reports failure
// - each input can mute buzzer, deactivate, unlock or force
// - local inputs default to mute, signaller off, cancel, force
// - sixteen remote flags; bits zero to three mirror local inputs
// - external port master reads status and writes remote flags
// - port supports ascii or rtu, address 1-255, baud, parity
// - ascii framing allows seven or eight data bits
// - detector status, concentrations, relays and inputs readable
`timescale 1ns/100ps
`include "roc_defines.svh"
module roc_relay_ctrl #(
  parameter int SEC_CYCLES = `ROC_TICK_S * `ROC_CLK_HZ,
  parameter int DEB_CYCLES = `ROC_DEB_MS * (`ROC_CLK_HZ / 1000)
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // detector image
  input  wire logic [31:0]  det_w1,
  input  wire logic [31:0]  det_w2,
  input  wire logic [31:0]  det_al,
  input  wire logic [31:0]  det_fail,
  input  wire logic [31:0]  det_meas,
  input  wire logic [31:0]  det_serv,
  input  wire logic [511:0] det_conc,
  input  wire logic         unit_fail,
  // front panel buttons and local inputs
  input  wire logic         btn_hold_cancel,
  input  wire logic         btn_ext_mute,
  input  wire logic         btn_buzz_mute,
  input  wire logic [3:0]   local_binary_input,
  // outputs
  output logic [7:0]        relay_output,
  output logic              buzzer_mute,
  // external link port settings
  output logic              mb_rtu,
  output logic              mb_data7,
  output logic [1:0]        mb_parity,
  output logic [2:0]        mb_baud_sel,
  output logic [7:0]        mb_addr
);
  localparam logic [24:0] SEC_LAST = 25'(SEC_CYCLES - 1);

  roc_pkg::roc_state_t s_q;
  roc_pkg::roc_state_t s_d;
  roc_di_if            di_if ();

  assign di_if.raw = local_binary_input;

  roc_debounce #(
    .DEB_CYCLES (DEB_CYCLES)
  ) u_deb (
    .pclk    (pclk),
    .presetn (presetn),
    .di      (di_if)
  );

  // apb decode
  logic        wr_en;
  logic        rd_setup;
  logic        out_hit;
  logic [2:0]  out_idx;
  logic [2:0]  out_reg;
  logic        map_ok;
  logic        val_ok;
  logic [31:0] rd_val;
  logic [22:0] src_now;
  logic [22:0] src_rise;
  logic [7:0]  exc;

  assign out_hit  = paddr[11:8] == 4'h1 && paddr[4:2] <= `ROC_O_FORCE;
  assign out_idx  = paddr[7:5];
  assign out_reg  = paddr[4:2];
  assign wr_en    = psel && penable && pwrite && map_ok && val_ok;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    map_ok = paddr[1:0] == 2'h0 && (out_hit || paddr <= `ROC_A_MUTE_SRC);
    val_ok = 1'b1;
    if (pwrite && paddr == `ROC_A_PORT_CFG) begin
      // invalid framing is refused so the serial engine never sees it
      val_ok = pwdata[15:8] != 8'h00 && pwdata[6:4] <= 3'h5 &&
               pwdata[3:2] != 2'h3 && !(pwdata[0] && pwdata[1]);
    end else if (pwrite && out_hit && out_reg == `ROC_O_DELAY) begin
      val_ok = pwdata[12:0] <= `ROC_MAX_DLY_S &&
               pwdata[28:16] <= `ROC_MAX_DLY_S;
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    if (out_hit) begin
      unique case (out_reg)
        `ROC_O_CFG:    rd_val = {22'h000000, s_q.cfg[out_idx]};
        `ROC_O_ZONE:   rd_val = s_q.zone[out_idx];
        `ROC_O_DELAY:  rd_val = {3'h0, s_q.off_dly[out_idx],
                                 3'h0, s_q.on_dly[out_idx]};
        `ROC_O_DEACT:  rd_val = {9'h000, s_q.deact_src[out_idx]};
        `ROC_O_CANCEL: rd_val = {9'h000, s_q.cancel_src[out_idx]};
        `ROC_O_FORCE:  rd_val = {9'h000, s_q.force_src[out_idx]};
        default:       rd_val = 32'h00000000;
      endcase
    end else begin
      unique case (paddr)
        `ROC_A_STATUS:   rd_val = {18'h00000, unit_fail, s_q.buzz_mute,
                                   di_if.clean, s_q.relay};
        `ROC_A_REMOTE:   rd_val = {16'h0000, s_q.remote};
        `ROC_A_PORT_CFG: rd_val = {16'h0000, s_q.port_cfg};
        `ROC_A_CONC_IDX: rd_val = {27'h0000000, s_q.conc_idx};
        `ROC_A_CONC:     rd_val = {16'h0000,
                                   det_conc[s_q.conc_idx*16 +: 16]};
        `ROC_A_DET_W1:   rd_val = det_w1;
        `ROC_A_DET_W2:   rd_val = det_w2;
        `ROC_A_DET_AL:   rd_val = det_al;
        `ROC_A_DET_FAIL: rd_val = det_fail;
        `ROC_A_DET_MEAS: rd_val = det_meas;
        `ROC_A_DET_SERV: rd_val = det_serv;
        `ROC_A_MUTE_SRC: rd_val = {9'h000, s_q.mute_src};
        default:         rd_val = 32'h00000000;
      endcase
    end
  end

  // source vector: local, remote flags, front panel buttons
  assign src_now  = {btn_buzz_mute, btn_ext_mute, btn_hold_cancel,
                     s_q.remote, di_if.clean};
  assign src_rise = src_now & ~s_q.src;

  // excitation per output
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      exc[i] = (s_q.cfg[i][`ROC_C_W1] && |(det_w1 & s_q.zone[i])) ||
               (s_q.cfg[i][`ROC_C_W2] && |(det_w2 & s_q.zone[i])) ||
               (s_q.cfg[i][`ROC_C_AL] && |(det_al & s_q.zone[i]));
      // hysteresis: once on, hold until the zone drops below warning one
      if (s_q.cfg[i][`ROC_C_HYST] && s_q.dly_st[i] &&
          |(det_w1 & s_q.zone[i])) begin
        exc[i] = 1'b1;
      end
      if (s_q.cfg[i][`ROC_C_FAIL] &&
          (|(det_fail & s_q.zone[i]) || unit_fail)) begin
        exc[i] = 1'b1;
      end
      if ((s_q.cfg[i][`ROC_C_MEAS] && |(det_meas & s_q.zone[i])) ||
          (s_q.cfg[i][`ROC_C_SERV] && |(det_serv & s_q.zone[i]))) begin
        exc[i] = 1'b1;
      end
    end
  end

  always_comb begin
    logic [12:0] target;
    logic        held;
    logic        pulse;
    target       = 13'h0000;
    held         = 1'b0;
    pulse        = 1'b0;
    s_d          = s_q;
    s_d.src      = src_now;
    s_d.tick     = s_q.tick_cnt == SEC_LAST;
    s_d.tick_cnt = s_d.tick ? 25'h0000000 : s_q.tick_cnt + 25'h0000001;
    if (rd_setup) begin
      s_d.prdata = rd_val;
    end
    for (int i = 0; i < 8; i++) begin
      // switch-on and switch-off delay, counted in whole seconds
      target = exc[i] ? s_q.on_dly[i] : s_q.off_dly[i];
      if (exc[i] == s_q.dly_st[i]) begin
        s_d.tmr[i] = 13'h0000;
      end else if (target == 13'h0000) begin
        s_d.dly_st[i] = exc[i];
        s_d.tmr[i]    = 13'h0000;
      end else if (s_q.tick) begin
        if (s_q.tmr[i] + 13'h0001 >= target) begin
          s_d.dly_st[i] = exc[i];
          s_d.tmr[i]    = 13'h0000;
        end else begin
          s_d.tmr[i] = s_q.tmr[i] + 13'h0001;
        end
      end
      // hold-on: released only by a cancel after excitation is gone
      if (!s_q.cfg[i][`ROC_C_HOLD]) begin
        s_d.hold[i] = 1'b0;
      end else if (s_q.dly_st[i]) begin
        s_d.hold[i] = 1'b1;
      end else if (|(src_rise & s_q.cancel_src[i])) begin
        s_d.hold[i] = 1'b0;
      end
      held = s_q.dly_st[i] || s_q.hold[i];
      // temporary deactivation lasts until excitation decays and any hold-on is released
      if (held && |(src_rise & s_q.deact_src[i])) begin
        s_d.tdeact[i] = 1'b1;
      end else if (!held) begin
        s_d.tdeact[i] = 1'b0;
      end
      s_d.act[i] = (held && !s_q.tdeact[i]) ||
                   |(src_now & s_q.force_src[i]);
      // valve pulses step on the shared second tick, so the first
      // pulse may be up to one second shorter than the rest
      if (!s_q.cfg[i][`ROC_C_VALVE]) begin
        s_d.vph[i] = 3'h0;
      end else if (s_q.vph[i] == 3'h0) begin
        if (s_d.act[i] && !s_q.act[i]) begin
          s_d.vph[i] = 3'h1;
        end
      end else if (s_q.tick) begin
        s_d.vph[i] = s_q.vph[i] == `ROC_VALVE_LAST ? 3'h0 :
                     s_q.vph[i] + 3'h1;
      end
      pulse = s_d.vph[i][0];
      s_d.relay[i] = s_q.cfg[i][`ROC_C_NEG] ^
                     (s_q.cfg[i][`ROC_C_VALVE] ? pulse : s_d.act[i]);
    end
    // buzzer mute clears when no threshold is exceeded; a new press wins
    if (|(src_rise & s_q.mute_src)) begin
      s_d.buzz_mute = 1'b1;
    end else if (!(|(det_w1 | det_w2 | det_al))) begin
      s_d.buzz_mute = 1'b0;
    end
    // register writes
    if (wr_en && out_hit) begin
      unique case (out_reg)
        `ROC_O_CFG:    s_d.cfg[out_idx]        = pwdata[9:0];
        `ROC_O_ZONE:   s_d.zone[out_idx]       = pwdata;
        `ROC_O_DELAY: begin
          s_d.on_dly[out_idx]  = pwdata[12:0];
          s_d.off_dly[out_idx] = pwdata[28:16];
        end
        `ROC_O_DEACT:  s_d.deact_src[out_idx]  = pwdata[22:0];
        `ROC_O_CANCEL: s_d.cancel_src[out_idx] = pwdata[22:0];
        `ROC_O_FORCE:  s_d.force_src[out_idx]  = pwdata[22:0];
        default:       s_d.cfg[out_idx]        = s_q.cfg[out_idx];
      endcase
    end else if (wr_en) begin
      if (paddr == `ROC_A_REMOTE) begin
        s_d.remote = pwdata[15:0];
      end
      if (paddr == `ROC_A_PORT_CFG) begin
        s_d.port_cfg = pwdata[15:0];
      end
      if (paddr == `ROC_A_CONC_IDX) begin
        s_d.conc_idx = pwdata[4:0];
      end
      if (paddr == `ROC_A_MUTE_SRC) begin
        s_d.mute_src = pwdata[22:0];
      end
    end
  end

  function automatic roc_pkg::roc_state_t rst_state();
    roc_pkg::roc_state_t r;
    r               = '0;
    r.cfg           = `ROC_RST_CFG;
    r.mute_src      = `ROC_RST_MUTE;
    r.deact_src[4]  = `ROC_RST_DEACT4;
    r.cancel_src[3] = `ROC_RST_CANCEL3;
    r.force_src[2]  = `ROC_RST_FORCE;
    r.force_src[4]  = `ROC_RST_FORCE;
    r.port_cfg      = `ROC_RST_PORT;
    for (int i = 0; i < 8; i++) begin
      r.zone[i] = `ROC_RST_ZONE;
    end
    return r;
  endfunction
  localparam roc_pkg::roc_state_t S_RST = rst_state();

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata       = s_q.prdata;
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !(map_ok && val_ok);
  assign relay_output = s_q.relay;
  assign buzzer_mute  = s_q.buzz_mute;
  assign mb_rtu       = s_q.port_cfg[0];
  assign mb_data7     = s_q.port_cfg[1];
  assign mb_parity    = s_q.port_cfg[3:2];
  assign mb_baud_sel  = s_q.port_cfg[6:4];
  assign mb_addr      = s_q.port_cfg[15:8];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hold3_idle;
    s_q.cfg[3][`ROC_C_HOLD] && s_q.hold[3] && !s_q.dly_st[3] &&
      !(|(src_rise & s_q.cancel_src[3]));
  endsequence

  property p_on_now;
    s_q.on_dly[0] == 13'h0000 && exc[0] && !s_q.dly_st[0] |=> s_q.dly_st[0];
  endproperty
  a_on_now: assert property (p_on_now)
    else $error("zero switch-on delay did not act at once");

  property p_on_tick;
    $rose(s_q.dly_st[0]) |->
      $past(s_q.tick) || $past(s_q.on_dly[0]) == 13'h0000;
  endproperty
  a_on_tick: assert property (p_on_tick)
    else $error("output switched on between second ticks");

  property p_off_tick;
    $fell(s_q.dly_st[0]) |->
      $past(s_q.tick) || $past(s_q.off_dly[0]) == 13'h0000;
  endproperty
  a_off_tick: assert property (p_off_tick)
    else $error("output switched off between second ticks");

  property p_hold;
    s_hold3_idle |=> s_q.hold[3];
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold-on released without cancel");

  property p_tdeact;
    (s_q.dly_st[4] || s_q.hold[4]) && |(src_rise & s_q.deact_src[4])
      |=> s_q.tdeact[4] ##1 !s_q.act[4] || |(src_now & s_q.force_src[4]);
  endproperty
  a_tdeact: assert property (p_tdeact)
    else $error("temporary deactivation had no effect");

  property p_valve_end;
    s_q.vph[1] == `ROC_VALVE_LAST && s_q.tick |=> s_q.vph[1] == 3'h0;
  endproperty
  a_valve_end: assert property (p_valve_end)
    else $error("valve pattern did not end after three pulses");

  property p_neg;
    presetn && !s_q.cfg[7][`ROC_C_VALVE] |=>
      s_q.relay[7] == (s_q.act[7] ^ $past(s_q.cfg[7][`ROC_C_NEG]));
  endproperty
  a_neg: assert property (p_neg)
    else $error("negation not applied to relay");

  property p_mute;
    |(src_rise & s_q.mute_src) |=> s_q.buzz_mute;
  endproperty
  a_mute: assert property (p_mute)
    else $error("mute request lost");

  property p_port_addr;
    psel && penable && pwrite && paddr == `ROC_A_PORT_CFG &&
      pwdata[15:8] == 8'h00 |-> pslverr ##1 mb_addr != 8'h00;
  endproperty
  a_port_addr: assert property (p_port_addr)
    else $error("slave address zero accepted");
endmodule

// ### roc_coil_model.sv
// Purpose: relay coils and the signallers they drive
// Assumes: coil follows its drive level, no contact bounce
// Notes:   counts energise events per coil to judge pulse patterns
`timescale 1ns/100ps
module roc_coil_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // coil drive
  input  wire logic [7:0] coil,
  // contacts and counts
  output logic [7:0]      no_closed,
  output logic [7:0][7:0] pulses
);
  logic [7:0] last_q;
  // energised coil closes the normally open contact
  assign no_closed = coil;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 8'h00;
      pulses <= '0;
    end else begin
      last_q <= coil;
      for (int i = 0; i < 8; i++) begin
        if (coil[i] && !last_q[i]) begin
          pulses[i] <= pulses[i] + 8'h01;
        end
      end
    end
  end
endmodule

// ### tb_roc_relay_ctrl.sv
// Purpose: self-checking bench of the relay output controller
// Assumes: short second tick and debounce to keep the run brief
// Notes:   apb master waits on pready; watchdog bounds the run
`timescale 1ns/100ps
`include "roc_defines.svh"
module tb_roc_relay_ctrl;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        uf, bhc, bem, bbm, err, bzm, mrt, md7;
  logic [1:0]  mpa;
  logic [2:0]  mbs;
  logic [511:0] cc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w1, w2, al, fl, ms, sv;
  logic [3:0]  lbi;
  logic [7:0]  rly, mba, ncl;
  logic [7:0][7:0] pul;
  int          bad_count, checks;

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // one second is 20 clocks so delays fit the run
  roc_relay_ctrl #(.SEC_CYCLES(20), .DEB_CYCLES(4)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .det_w1(w1), .det_w2(w2), .det_al(al), .det_fail(fl),
    .det_meas(ms), .det_serv(sv), .det_conc(cc), .unit_fail(uf),
    .btn_hold_cancel(bhc), .btn_ext_mute(bem), .btn_buzz_mute(bbm),
    .local_binary_input(lbi), .relay_output(rly), .buzzer_mute(bzm),
    .mb_rtu(mrt), .mb_data7(md7), .mb_parity(mpa), .mb_baud_sel(mbs),
    .mb_addr(mba)
  );

  roc_coil_model coils (
    .pclk(pclk), .presetn(presetn), .coil(rly), .no_closed(ncl),
    .pulses(pul)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic press(input logic hold);
    if (hold) bhc <= 1'b1;
    else bem <= 1'b1;
    cyc(4);
    bhc <= 1'b0;
    bem <= 1'b0;
    cyc(4);
  endtask

  task automatic t_reset;
    chk(32'(rly), 32'h80);
    chk(32'(ncl), 32'h80);
    chk(32'(mba), 32'h01);
    apb(0, `ROC_A_PORT_CFG, 32'h0);
    chk(rd, 32'h111);
    chk(32'(err), 32'h0);
    apb(0, 12'h300, 32'h0);
    chk(32'(err), 32'h1);
    apb(1, `ROC_A_PORT_CFG, 32'h0);
    chk(32'(err), 32'h1);
    apb(1, `ROC_A_PORT_CFG, 32'h113);
    chk(32'(err), 32'h1);
    apb(1, `ROC_A_PORT_CFG, 32'h112);
    chk(32'(err), 32'h0);
    cyc(1);
    chk(32'({mrt, md7, mpa, mbs}), 32'h21);
    cc[95:80] <= 16'h1A2B;
    apb(1, `ROC_A_CONC_IDX, 32'h5);
    apb(0, `ROC_A_CONC, 32'h0);
    chk(rd, 32'h1A2B);
    apb(0, `ROC_A_MUTE_SRC, 32'h0);
    chk(rd, 32'h400011);
    apb(0, 12'h160, 32'h0);
    chk(rd, 32'h041);
    $display("test reset done");
  endtask

  task automatic t_levels;
    w1 <= 32'h1;
    cyc(5);
    chk(32'(rly), 32'h89);
    w2 <= 32'h1;
    al <= 32'h1;
    cyc(5);
    chk(32'(rly), 32'h9F);
    ms <= 32'h2;
    sv <= 32'h2;
    cyc(5);
    chk(32'(rly), 32'hFF);
    fl <= 32'h4;
    cyc(5);
    chk(32'(rly), 32'h7F);
    fl <= 32'h0;
    uf <= 1'b1;
    cyc(5);
    chk(32'(rly), 32'h7F);
    uf <= 1'b0;
    {w1, w2, al, ms, sv} <= '0;
    cyc(5);
    chk(32'(rly), 32'h88);
    apb(0, `ROC_A_STATUS, 32'h0);
    chk(rd & 32'hFF, 32'h88);
    press(1'b1);
    chk(32'(rly), 32'h80);
    $display("test levels done");
  endtask

  task automatic t_deact;
    al <= 32'h1;
    cyc(5);
    chk(32'(rly), 32'h94);
    press(1'b0);
    chk(32'(rly), 32'h84);
    al <= 32'h0;
    cyc(5);
    chk(32'(rly), 32'h80);
    $display("test deactivate done");
  endtask

  task automatic t_hyst;
    apb(1, 12'h140, 32'h204);
    w1 <= 32'h1;
    al <= 32'h1;
    cyc(5);
    chk(32'(rly[2]), 32'h1);
    al <= 32'h0;
    cyc(5);
    chk(32'(rly[2]), 32'h1);
    w1 <= 32'h0;
    cyc(5);
    chk(32'(rly[2]), 32'h0);
    press(1'b1);
    chk(32'(rly), 32'h80);
    $display("test hysteresis done");
  endtask

  task automatic t_force;
    apb(1, `ROC_A_REMOTE, 32'h8);
    cyc(4);
    chk(32'(rly), 32'h94);
    apb(1, `ROC_A_REMOTE, 32'h0);
    cyc(4);
    chk(32'(rly), 32'h80);
    lbi <= 4'h8;
    cyc(3);
    chk(32'(rly), 32'h80);
    cyc(20);
    chk(32'(rly), 32'h94);
    apb(0, `ROC_A_STATUS, 32'h0);
    chk(rd & 32'hF00, 32'h800);
    lbi <= 4'h0;
    cyc(20);
    chk(32'(rly), 32'h80);
    $display("test force done");
  endtask

  task automatic t_mute;
    w2 <= 32'h1;
    lbi <= 4'h1;
    cyc(12);
    chk(32'(bzm), 32'h1);
    lbi <= 4'h0;
    w2 <= 32'h0;
    cyc(12);
    chk(32'(bzm), 32'h0);
    w2 <= 32'h1;
    bbm <= 1'b1;
    cyc(4);
    chk(32'(bzm), 32'h1);
    w2 <= 32'h0;
    bbm <= 1'b0;
    cyc(4);
    chk(32'(bzm), 32'h0);
    $display("test mute done");
  endtask

  task automatic t_delay;
    apb(1, 12'h104, 32'h2);
    apb(1, 12'h108, 32'h0002_0002);
    apb(1, 12'h108, 32'h0000_1771);
    chk(32'(err), 32'h1);
    w1 <= 32'h1;
    cyc(60);
    chk(32'(rly[0]), 32'h0);
    w1 <= 32'h2;
    cyc(10);
    chk(32'(rly[0]), 32'h0);
    cyc(40);
    chk(32'(rly[0]), 32'h1);
    w1 <= 32'h0;
    cyc(10);
    chk(32'(rly[0]), 32'h1);
    cyc(40);
    chk(32'(rly[0]), 32'h0);
    apb(1, `ROC_A_REMOTE, 32'h4);
    apb(1, `ROC_A_REMOTE, 32'h0);
    cyc(4);
    chk(32'(rly), 32'h80);
    $display("test delay done");
  endtask

  task automatic t_valve;
    logic [7:0] p;
    apb(1, 12'h120, 32'h081);
    apb(1, 12'h1A0, 32'h110);
    cyc(4);
    chk(32'(rly[5]), 32'h1);
    p = pul[1];
    w1 <= 32'h1;
    cyc(200);
    chk(32'(pul[1] - p), 32'h3);
    chk(32'(rly[1]), 32'h0);
    w1 <= 32'h0;
    cyc(10);
    press(1'b1);
    chk(32'(rly), 32'hA0);
    $display("test valve done");
  endtask

  task automatic results;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, uf, bhc, bem, bbm} = '0;
    {paddr, pwdata, w1, w2, al, fl, ms, sv, lbi, cc} = '0;
    cyc(16);
    presetn <= 1'b1;
    cyc(3);
    t_reset;
    t_levels;
    t_deact;
    t_hyst;
    t_force;
    t_mute;
    t_delay;
    t_valve;
    results;
  end

  // tests take about 630 clocks; a hang is cut well after that
  initial begin
    cyc(6000);
    bad_count++;
    $display("Error %0t: watchdog expired", $time);
    results;
  end
endmodule
